// ==== hw/gdc_pkg.sv ====
package gdc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] GDC_ADDR_HIGH_SIDE = 4'h6;
  localparam logic [3:0] GDC_ADDR_LOW_SIDE  = 4'h7;
  localparam logic [7:0] GDC_RESET_HIGH     = 8'hff;
  localparam logic [7:0] GDC_RESET_LOW      = 8'hff;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int         GDC_SOURCE_MSB     = 7;
  localparam int         GDC_SOURCE_LSB     = 4;
  localparam int         GDC_SINK_MSB       = 3;
  localparam int         GDC_SINK_LSB       = 0;
  // ----------------------------------------------------------------
  // lock field codes
  // ----------------------------------------------------------------
  localparam logic [2:0] GDC_LOCK_CODE      = 3'h6;
  localparam logic [2:0] GDC_UNLOCK_CODE    = 3'h3;
  localparam logic       GDC_LOCKED_RESET   = 1'h0;
  // ----------------------------------------------------------------
  // read defaults
  // ----------------------------------------------------------------
  localparam logic [7:0] GDC_READ_IDLE      = 8'h00;
endpackage

// ==== hw/gdc_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// How it works
// - high source code in bits 7-4 of high register, reset 1111b, 16-step scale.
// - high sink code in bits 3-0 of high register, reset 1111b, same scale.
// - low source code in bits 7-4 of low register, reset 1111b, same scale.
// - low sink code in bits 3-0 of low register, reset 1111b, same scale.
// - low register lives at offset 7h and resets to FFh.
// - high register lives at offset 6h and resets to FFh.
// - lock code 110b blocks writes; 011b unlocks them again.
module gdc_top
  import gdc_pkg::*;
(
  // clock and reset
  input  wire logic       MCLK,
  input  wire logic       RESET_N,
  // register port
  input  wire logic       WR_EN,
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  output var  logic [7:0] RDATA,
  // lock field value from control register
  input  wire logic [2:0] LOCK_FIELD,
  input  wire logic       LOCK_WR,
  // drive stage codes
  output var  logic [3:0] HIGH_SOURCE_CURRENT_CODE,
  output var  logic [3:0] HIGH_SINK_CURRENT_CODE,
  output var  logic [3:0] LOW_SOURCE_CURRENT_CODE,
  output var  logic [3:0] LOW_SINK_CURRENT_CODE
);
  import gdc_pkg::*;

  // ----------------------------------------------------------------
  // entry indices
  // ----------------------------------------------------------------
  localparam int HIGH_IDX = 0;
  localparam int LOW_IDX  = 1;
  localparam int ENTRIES  = 2;

  // ----------------------------------------------------------------
  // lock state
  // ----------------------------------------------------------------
  logic locked_q;
  logic locked_d;
  logic lock_take;
  logic unlock_take;

  assign lock_take   = LOCK_WR && (LOCK_FIELD == GDC_LOCK_CODE);
  assign unlock_take = LOCK_WR && (LOCK_FIELD == GDC_UNLOCK_CODE);

  always_comb begin
    locked_d = locked_q;
    if (lock_take) begin
      locked_d = 1'h1;
    end else if (unlock_take) begin
      locked_d = 1'h0;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      locked_q <= GDC_LOCKED_RESET;
    end else begin
      locked_q <= locked_d;
    end
  end

  // ----------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------
  logic write_ok;

  assign write_ok = WR_EN && !locked_q;

  // ----------------------------------------------------------------
  // drive current registers, one entry per bridge side
  // ----------------------------------------------------------------
  for (genvar i = 0; i < ENTRIES; i = i + 1) begin : g_entry
    localparam logic [3:0] ENTRY_ADDR  = (i == HIGH_IDX) ? GDC_ADDR_HIGH_SIDE : GDC_ADDR_LOW_SIDE;
    localparam logic [7:0] ENTRY_RESET = (i == HIGH_IDX) ? GDC_RESET_HIGH : GDC_RESET_LOW;

    logic [7:0] value_q;
    logic [7:0] value_d;

    always_comb begin
      value_d = value_q;
      if (write_ok && (ADDR == ENTRY_ADDR)) begin
        value_d = WDATA;
      end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
        value_q <= ENTRY_RESET;
      end else begin
        value_q <= value_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // entry views
  // ----------------------------------------------------------------
  logic [7:0] high_value;
  logic [7:0] low_value;
  logic [7:0] high_next;
  logic [7:0] low_next;

  assign high_value = g_entry[HIGH_IDX].value_q;
  assign low_value  = g_entry[LOW_IDX].value_q;
  assign high_next  = g_entry[HIGH_IDX].value_d;
  assign low_next   = g_entry[LOW_IDX].value_d;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb begin
    unique case (ADDR)
      GDC_ADDR_HIGH_SIDE: rdata_d = high_next;
      GDC_ADDR_LOW_SIDE:  rdata_d = low_next;
      default:            rdata_d = GDC_READ_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_q <= GDC_READ_IDLE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign RDATA                    = rdata_q;
  assign HIGH_SOURCE_CURRENT_CODE = high_value[GDC_SOURCE_MSB:GDC_SOURCE_LSB];
  assign HIGH_SINK_CURRENT_CODE   = high_value[GDC_SINK_MSB:GDC_SINK_LSB];
  assign LOW_SOURCE_CURRENT_CODE  = low_value[GDC_SOURCE_MSB:GDC_SOURCE_LSB];
  assign LOW_SINK_CURRENT_CODE    = low_value[GDC_SINK_MSB:GDC_SINK_LSB];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_high_write: assert property (@(posedge MCLK) disable iff (!RESET_N)
    write_ok && (ADDR == GDC_ADDR_HIGH_SIDE) |=> high_value == $past(WDATA))
    else $error("high register write lost");

  a_low_write: assert property (@(posedge MCLK) disable iff (!RESET_N)
    write_ok && (ADDR == GDC_ADDR_LOW_SIDE) |=> low_value == $past(WDATA))
    else $error("low register write lost");

  a_lock_hold: assert property (@(posedge MCLK) disable iff (!RESET_N)
    locked_q |=> $stable(high_value) && $stable(low_value))
    else $error("write accepted while locked");

  a_lock_set: assert property (@(posedge MCLK) disable iff (!RESET_N)
    LOCK_WR && (LOCK_FIELD == GDC_LOCK_CODE) |=> locked_q)
    else $error("lock not taken");

  a_lock_clear: assert property (@(posedge MCLK) disable iff (!RESET_N)
    LOCK_WR && (LOCK_FIELD == GDC_UNLOCK_CODE) |=> !locked_q)
    else $error("unlock not taken");

  a_lock_other: assert property (@(posedge MCLK) disable iff (!RESET_N)
    LOCK_WR && (LOCK_FIELD != GDC_LOCK_CODE) && (LOCK_FIELD != GDC_UNLOCK_CODE) |=> locked_q == $past(locked_q))
    else $error("other lock code changed the lock");

  a_hs_source: assert property (@(posedge MCLK) disable iff (!RESET_N)
    write_ok && (ADDR == GDC_ADDR_HIGH_SIDE) |=> HIGH_SOURCE_CURRENT_CODE == $past(WDATA[GDC_SOURCE_MSB:GDC_SOURCE_LSB]))
    else $error("high source code wrong");

  a_hs_sink: assert property (@(posedge MCLK) disable iff (!RESET_N)
    write_ok && (ADDR == GDC_ADDR_HIGH_SIDE) |=> HIGH_SINK_CURRENT_CODE == $past(WDATA[GDC_SINK_MSB:GDC_SINK_LSB]))
    else $error("high sink code wrong");

  a_ls_source: assert property (@(posedge MCLK) disable iff (!RESET_N)
    write_ok && (ADDR == GDC_ADDR_LOW_SIDE) |=> LOW_SOURCE_CURRENT_CODE == $past(WDATA[GDC_SOURCE_MSB:GDC_SOURCE_LSB]))
    else $error("low source code wrong");

  a_ls_sink: assert property (@(posedge MCLK) disable iff (!RESET_N)
    write_ok && (ADDR == GDC_ADDR_LOW_SIDE) |=> LOW_SINK_CURRENT_CODE == $past(WDATA[GDC_SINK_MSB:GDC_SINK_LSB]))
    else $error("low sink code wrong");

  a_high_hold: assert property (@(posedge MCLK) disable iff (!RESET_N)
    !(write_ok && (ADDR == GDC_ADDR_HIGH_SIDE)) |=> $stable(high_value))
    else $error("high codes moved without a write");

  a_low_hold: assert property (@(posedge MCLK) disable iff (!RESET_N)
    !(write_ok && (ADDR == GDC_ADDR_LOW_SIDE)) |=> $stable(low_value))
    else $error("low codes moved without a write");

  a_read_high: assert property (@(posedge MCLK) disable iff (!RESET_N)
    ADDR == GDC_ADDR_HIGH_SIDE |=> RDATA == high_value)
    else $error("high read value wrong");

  a_read_back: assert property (@(posedge MCLK) disable iff (!RESET_N)
    ADDR == GDC_ADDR_LOW_SIDE |=> RDATA == low_value)
    else $error("read value wrong");

  a_read_unmapped: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (ADDR != GDC_ADDR_HIGH_SIDE) && (ADDR != GDC_ADDR_LOW_SIDE) |=> RDATA == GDC_READ_IDLE)
    else $error("unmapped read value wrong");

  // ----------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------
  c_write_high: cover property (@(posedge MCLK) disable iff (!RESET_N)
    WR_EN && !locked_q && ADDR == GDC_ADDR_HIGH_SIDE);

  c_write_low: cover property (@(posedge MCLK) disable iff (!RESET_N)
    WR_EN && !locked_q && ADDR == GDC_ADDR_LOW_SIDE);

  c_locked_write: cover property (@(posedge MCLK) disable iff (!RESET_N)
    WR_EN && locked_q);

  c_lock_with_write: cover property (@(posedge MCLK) disable iff (!RESET_N)
    write_ok && lock_take);

  c_unlock: cover property (@(posedge MCLK) disable iff (!RESET_N)
    locked_q ##1 !locked_q);
endmodule
`default_nettype wire

// ==== bench/gate_drive_current_config_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module gate_drive_current_config_tb;
  import gdc_pkg::*;
  logic        mclk = 0, reset_n = 0, wr_en = 0, lock_wr = 0;
  logic [3:0]  addr = 4'h0, hsrc, hsnk, lsrc, lsnk;
  logic [7:0]  wdata = 8'h00, rdata, hi, lo;
  logic [2:0]  lock_field = 3'h0;
  int          fail_count = 0, compares = 0;
  logic [27:0] rows [6] = '{28'h61212ff, 28'h7a512a5, 28'h60f0fa5, 28'h7f00ff0, 28'h60000f0, 28'h7ff00ff};
  gdc_top gdc_top_inst (.MCLK(mclk), .RESET_N(reset_n), .WR_EN(wr_en), .ADDR(addr), .WDATA(wdata),
    .RDATA(rdata), .LOCK_FIELD(lock_field), .LOCK_WR(lock_wr), .HIGH_SOURCE_CURRENT_CODE(hsrc),
    .HIGH_SINK_CURRENT_CODE(hsnk), .LOW_SOURCE_CURRENT_CODE(lsrc), .LOW_SINK_CURRENT_CODE(lsnk));
  initial forever #5 mclk = ~mclk;
  // ----------------------------------------------------------------
  // shared checks and bus cycles
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk_all();
    chk("high codes", hi, {hsrc, hsnk});
    chk("low codes", lo, {lsrc, lsnk});
    chk("read data", (addr == GDC_ADDR_HIGH_SIDE) ? hi : (addr == GDC_ADDR_LOW_SIDE) ? lo : 8'h00, rdata);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input bit ok);
    addr = a;
    wdata = d;
    wr_en = 1;
    @(negedge mclk);
    if (ok && a == GDC_ADDR_HIGH_SIDE) hi = d;
    if (ok && a == GDC_ADDR_LOW_SIDE) lo = d;
    chk_all();
  endtask
  task automatic lk(input logic [2:0] c);
    lock_field = c;
    lock_wr = 1;
    @(negedge mclk);
    lock_wr = 0;
  endtask
  task automatic rst();
    reset_n = 0;
    addr = GDC_ADDR_HIGH_SIDE;
    repeat (20) @(negedge mclk);
    reset_n = 1;
    hi = GDC_RESET_HIGH;
    lo = GDC_RESET_LOW;
    @(negedge mclk);
    chk_all();
    addr = GDC_ADDR_LOW_SIDE;
    @(negedge mclk);
    chk_all();
    $display("reset test done");
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    stop_test();
  end
  initial begin
    rst();
    addr = 4'h5;
    @(negedge mclk);
    chk("unmapped read", 8'h00, rdata);
    foreach (rows[i]) begin
      hi = rows[i][15:8];
      lo = rows[i][7:0];
      wr(rows[i][27:24], rows[i][23:16], 0);
    end
    wr_en = 0;
    $display("row test done");
    lk(GDC_LOCK_CODE);
    wr(GDC_ADDR_HIGH_SIDE, 8'h55, 0);
    wr_en = 0;
    lk(3'h5);
    wr(GDC_ADDR_LOW_SIDE, 8'h55, 0);
    wr_en = 0;
    lk(GDC_UNLOCK_CODE);
    wr(GDC_ADDR_LOW_SIDE, 8'h3c, 1);
    wr(GDC_ADDR_HIGH_SIDE, 8'ha1, 1);
    lock_field = GDC_LOCK_CODE;
    lock_wr = 1;
    wr(GDC_ADDR_HIGH_SIDE, 8'h77, 1);
    lock_wr = 0;
    wr(GDC_ADDR_HIGH_SIDE, 8'h88, 0);
    wr_en = 0;
    $display("lock test done");
    rst();
    wr(GDC_ADDR_HIGH_SIDE, 8'h5a, 1);
    wr(4'h5, 8'h99, 1);
    wr_en = 0;
    $display("reset unlock test done");
    stop_test();
  end
endmodule
`default_nettype wire
